// ### ctw_bus_model.sv
// Behavioural CAN bus seen from the transceiver: a wired-AND of our driver and a remote node.
// Assumes the testbench shares the core clock and calls send_wake between edges.
`timescale 1ns/10ps
module ctw_bus_model (
    // Clock.
    input wire logic core_clk_in,
    // Bus levels.
    input wire logic bus_tx_dom_in,
    output logic bus_rx_out
);
    logic hold_dom = 1'b0;
    // Dominant wins on the wire, so a remote node can clamp the bus.
    assign bus_rx_out = ~(bus_tx_dom_in | hold_dom);
    // Remote node sends dominant, recessive, dominant phases.
    task automatic send_wake(input int d1, input int r, input int d2);
        hold_dom = 1'b1;
        repeat (d1) @(posedge core_clk_in);
        #10 hold_dom = 1'b0;
        repeat (r) @(posedge core_clk_in);
        #10 hold_dom = 1'b1;
        repeat (d2) @(posedge core_clk_in);
        #10 hold_dom = 1'b0;
    endtask : send_wake
endmodule : ctw_bus_model

// ### ctw_can_xcvr_ctrl.sv
// Transceiver mode control, wake handling, termination and fault supervision.
// Assumes register-side inputs are on the core clock; pin inputs are asynchronous.
`timescale 1ns/10ps
module ctw_can_xcvr_ctrl import ctw_pkg::*; #(
    parameter logic [CTW_CNT_W-1:0] WAKE_MAX_CYC = CTW_WAKE_MAX_CYC,
    parameter logic [CTW_CNT_W-1:0] TX_TO_CYC = CTW_TX_TO_CYC,
    parameter logic [CTW_CNT_W-1:0] BUS_TO_CYC = CTW_BUS_TO_CYC,
    parameter logic [CTW_CNT_W-1:0] SILENCE_CYC = CTW_SILENCE_CYC
) (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Mode control from the register side.
    input wire logic mode_wr_in,
    input wire logic [1:0] mode_wdata_in,
    input wire logic [2:0] sbc_mode_in,
    output logic [1:0] mode_out,
    // Status flags and their clear strobes.
    input wire logic wake_flag_clr_in,
    input wire logic can_fail_clr_in,
    input wire logic uv_flag_clr_in,
    output logic bus_wake_flag_out,
    output logic can_fail_flag_out,
    output logic bus_supply_uv_flag_out,
    // Watchdog and chip mode requests.
    input wire logic wdog_on_bus_wake_in,
    input wire logic wdog_enabled_in,
    output logic wdog_auto_en_out,
    output logic restart_req_out,
    // Controller pins.
    input wire logic tx_data_pin_in,
    output logic rx_data_pin_out,
    output logic irq_out_n,
    // Bus front end.
    input wire logic bus_rx_in,
    input wire logic transceiver_supply_uv_in,
    output logic bus_tx_dom_out,
    output logic drv_en_out,
    output logic [1:0] term_sel_out
);
    // Everything that holds state, in one register.
    typedef struct packed {
        logic [1:0] tx_dom_sync;
        logic [1:0] bus_dom_sync;
        logic [1:0] uv_sync;
        logic [1:0] mode;
        logic [2:0] sbc_prev;
        logic woken;
        logic sil_done;
        logic [CTW_CNT_W-1:0] sil_cnt;
        logic [CTW_CNT_W-1:0] tx_cnt;
        logic txto;
        logic [CTW_CNT_W-1:0] bus_cnt;
        logic clamp_seen;
        logic can_fail;
        logic uv_flag;
        logic wake_flag;
        logic irq;
        logic wd_req;
        logic restart_req;
        logic rx_low;
        logic tx_dom_o;
        logic drv_en_o;
        logic [1:0] term_o;
    } ctw_main_state_t;

    ctw_main_state_t st_ff;
    ctw_main_state_t nxt_st;

    ctw_wake_if wif();

    logic tx_dom;
    logic bus_dom;
    logic uv_act;
    logic sbc_chg;
    logic rearm_chip;
    logic wake_hit;

    // Synchronised pin levels; only the second stage of each pair is used.
    assign tx_dom = st_ff.tx_dom_sync[1];
    assign bus_dom = st_ff.bus_dom_sync[1];
    assign uv_act = st_ff.mode[1] & st_ff.uv_sync[1];

    // Chip mode entry into a low-power or safe mode rearms the detector.
    assign sbc_chg = (sbc_mode_in != st_ff.sbc_prev);
    assign rearm_chip = sbc_chg && (sbc_mode_in == CTW_SBC_STOP || sbc_mode_in == CTW_SBC_SLEEP
        || sbc_mode_in == CTW_SBC_FAILSAFE);
    assign wake_hit = wif.hit;

    // The detector only listens in Wake Capable before a wake, never in Off.
    assign wif.enable = (st_ff.mode == CTW_MODE_WAKE) && !st_ff.woken;
    assign wif.bus_dom = bus_dom;

    ctw_wake_pattern #(
        .MIN_CYC(CTW_WAKE_MIN_CYC),
        .MAX_CYC(WAKE_MAX_CYC)
    ) u_wake_pattern (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .wif(wif)
    );

    // Next-state logic for the whole block.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tx_dom_sync = {st_ff.tx_dom_sync[0], ~tx_data_pin_in};
        nxt_st.bus_dom_sync = {st_ff.bus_dom_sync[0], ~bus_rx_in};
        nxt_st.uv_sync = {st_ff.uv_sync[0], transceiver_supply_uv_in};
        nxt_st.sbc_prev = sbc_mode_in;
        nxt_st.wd_req = 1'b0;
        nxt_st.restart_req = 1'b0;

        // Mode writes are accepted only where the chip mode allows them.
        if (sbc_mode_in == CTW_SBC_FAILSAFE) begin
            nxt_st.mode = CTW_MODE_WAKE;
        end else if (mode_wr_in) begin
            case (mode_wdata_in)
                CTW_MODE_OFF: nxt_st.mode = CTW_MODE_OFF;
                CTW_MODE_WAKE: begin
                    if (sbc_mode_in == CTW_SBC_STOP || sbc_mode_in == CTW_SBC_SLEEP
                        || sbc_mode_in == CTW_SBC_RESTART || sbc_mode_in == CTW_SBC_NORMAL)
                        nxt_st.mode = CTW_MODE_WAKE;
                end
                CTW_MODE_RXO: begin
                    if (sbc_mode_in == CTW_SBC_NORMAL || sbc_mode_in == CTW_SBC_STOP)
                        nxt_st.mode = CTW_MODE_RXO;
                end
                CTW_MODE_NORM: begin
                    // Normal transmission is entered only with the chip in Normal.
                    if (sbc_mode_in == CTW_SBC_NORMAL) nxt_st.mode = CTW_MODE_NORM;
                end
                default: nxt_st.mode = st_ff.mode;
            endcase
        end

        // Wake latch: leaving Wake Capable or a chip entry rearms it.
        // The mode field itself is never touched by a wake.
        if (st_ff.mode != CTW_MODE_WAKE || rearm_chip) nxt_st.woken = 1'b0;
        if (wake_hit) nxt_st.woken = 1'b1;

        // Wake reaction per chip mode; a new wake wins over a clear.
        if (wake_flag_clr_in) begin
            nxt_st.wake_flag = 1'b0;
            nxt_st.irq = 1'b0;
        end
        if (wake_hit) begin
            nxt_st.wake_flag = 1'b1;
            case (sbc_mode_in)
                CTW_SBC_NORMAL: nxt_st.irq = 1'b1;
                CTW_SBC_STOP: begin
                    // Stop is kept; only the controller moves the chip on.
                    nxt_st.irq = 1'b1;
                    nxt_st.wd_req = wdog_on_bus_wake_in && !wdog_enabled_in;
                end
                CTW_SBC_SLEEP: nxt_st.restart_req = 1'b1;
                CTW_SBC_FAILSAFE: nxt_st.restart_req = 1'b1;
                default: nxt_st.restart_req = 1'b0;
            endcase
        end

        // Bus silence timer gates the ground termination in Wake Capable.
        if (st_ff.mode != CTW_MODE_WAKE) begin
            nxt_st.sil_cnt = '0;
            nxt_st.sil_done = 1'b0;
        end else if (!st_ff.sil_done) begin
            if (bus_dom) nxt_st.sil_cnt = '0;
            else if (st_ff.sil_cnt >= SILENCE_CYC) nxt_st.sil_done = 1'b1;
            else nxt_st.sil_cnt = ctw_sat_inc(st_ff.sil_cnt);
        end

        // Transmit time-out watches the pin, not the driver, so it clears
        // when the controller itself releases the line or the mode leaves Normal.
        if (st_ff.mode == CTW_MODE_NORM && tx_dom) begin
            nxt_st.tx_cnt = ctw_sat_inc(st_ff.tx_cnt);
            if (st_ff.tx_cnt >= TX_TO_CYC) nxt_st.txto = 1'b1;
        end else begin
            nxt_st.tx_cnt = '0;
            nxt_st.txto = 1'b0;
        end

        // Bus clamping reports once per dominant episode.
        if (st_ff.mode[1] && bus_dom) begin
            nxt_st.bus_cnt = ctw_sat_inc(st_ff.bus_cnt);
        end else begin
            nxt_st.bus_cnt = '0;
            nxt_st.clamp_seen = 1'b0;
        end

        // Failure flag: set by either time-out, and a set beats a clear.
        if (can_fail_clr_in) nxt_st.can_fail = 1'b0;
        if (!st_ff.txto && nxt_st.txto) nxt_st.can_fail = 1'b1;
        if (st_ff.mode[1] && bus_dom && st_ff.bus_cnt >= BUS_TO_CYC && !st_ff.clamp_seen) begin
            nxt_st.clamp_seen = 1'b1;
            nxt_st.can_fail = 1'b1;
        end

        // Supply undervoltage flag.
        if (uv_flag_clr_in) nxt_st.uv_flag = 1'b0;
        if (uv_act) nxt_st.uv_flag = 1'b1;

        // Driver stays off in Receive Only, on time-out and on undervoltage,
        // and comes back by itself when the cause goes away.
        nxt_st.drv_en_o = (st_ff.mode == CTW_MODE_NORM) && !nxt_st.txto && !uv_act;
        nxt_st.tx_dom_o = nxt_st.drv_en_o && tx_dom;

        // Receive pin: latched low after a wake, bus level when receiving.
        if (nxt_st.woken) nxt_st.rx_low = 1'b1;
        else nxt_st.rx_low = st_ff.mode[1] && bus_dom;

        // Termination by mode.
        case (st_ff.mode)
            CTW_MODE_NORM: nxt_st.term_o = CTW_TERM_HALF;
            CTW_MODE_RXO: nxt_st.term_o = st_ff.uv_sync[1] ? CTW_TERM_FIXED : CTW_TERM_HALF;
            CTW_MODE_WAKE: begin
                if (st_ff.woken) nxt_st.term_o = CTW_TERM_FIXED;
                else if (st_ff.sil_done) nxt_st.term_o = CTW_TERM_GND;
                else nxt_st.term_o = CTW_TERM_FLOAT;
            end
            default: nxt_st.term_o = CTW_TERM_FLOAT;
        endcase
    end

    // State register; reset gives Off mode and all outputs idle.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) st_ff <= '0;
        else st_ff <= nxt_st;
    end

    // Outputs straight from the state register.
    assign mode_out = st_ff.mode;
    assign bus_wake_flag_out = st_ff.wake_flag;
    assign can_fail_flag_out = st_ff.can_fail;
    assign bus_supply_uv_flag_out = st_ff.uv_flag;
    assign wdog_auto_en_out = st_ff.wd_req;
    assign restart_req_out = st_ff.restart_req;
    assign rx_data_pin_out = ~st_ff.rx_low;
    assign irq_out_n = ~st_ff.irq;
    assign bus_tx_dom_out = st_ff.tx_dom_o;
    assign drv_en_out = st_ff.drv_en_o;
    assign term_sel_out = st_ff.term_o;

    // A wake while in Stop or Normal with its chip reaction.
    sequence s_wake_in_stop_normal;
        wake_hit && (sbc_mode_in == CTW_SBC_STOP || sbc_mode_in == CTW_SBC_NORMAL);
    endsequence

    sequence s_wake_signalled;
        !irq_out_n && bus_wake_flag_out && !rx_data_pin_out;
    endsequence

    AST_OFF_DEAF: assert property (@(posedge core_clk_in) disable iff (rst_in)
        st_ff.mode == CTW_MODE_OFF |-> !wif.enable)
        else $error("Wake detector listening while Off.");

    AST_RXO_NO_DRIVE: assert property (@(posedge core_clk_in) disable iff (rst_in)
        st_ff.mode == CTW_MODE_RXO |=> !drv_en_out && !bus_tx_dom_out)
        else $error("Driver active in Receive Only.");

    AST_RXO_ACCEPT: assert property (@(posedge core_clk_in) disable iff (rst_in)
        mode_wr_in && mode_wdata_in == CTW_MODE_RXO && sbc_mode_in != CTW_SBC_NORMAL
        && sbc_mode_in != CTW_SBC_STOP && sbc_mode_in != CTW_SBC_FAILSAFE |=> $stable(mode_out))
        else $error("Receive Only taken outside Normal or Stop.");

    AST_FS_WAKE: assert property (@(posedge core_clk_in) disable iff (rst_in)
        sbc_mode_in == CTW_SBC_FAILSAFE |=> mode_out == CTW_MODE_WAKE)
        else $error("Fail-Safe did not force Wake Capable.");

    AST_WAKE_HOLD: assert property (@(posedge core_clk_in) disable iff (rst_in)
        st_ff.woken && st_ff.mode == CTW_MODE_WAKE && !rearm_chip |=> !rx_data_pin_out)
        else $error("Receive pin released while still woken.");

    AST_WAKE_KEEPS_MODE: assert property (@(posedge core_clk_in) disable iff (rst_in)
        $rose(st_ff.woken) |-> mode_out == CTW_MODE_WAKE)
        else $error("Mode field changed by a wake.");

    AST_STOP_SIGNAL: assert property (@(posedge core_clk_in) disable iff (rst_in)
        s_wake_in_stop_normal |=> s_wake_signalled)
        else $error("Wake in Stop or Normal not signalled.");

    AST_SLEEP_QUIET: assert property (@(posedge core_clk_in) disable iff (rst_in)
        wake_hit && sbc_mode_in == CTW_SBC_SLEEP && irq_out_n && !wake_flag_clr_in
        |=> restart_req_out && irq_out_n && bus_wake_flag_out)
        else $error("Sleep wake mishandled.");

    AST_TXTO_FAIL: assert property (@(posedge core_clk_in) disable iff (rst_in)
        $rose(st_ff.txto) |-> st_ff.can_fail && !drv_en_out && !bus_tx_dom_out
        && $stable(mode_out)) else $error("Time-out left driver on or flag clear.");

    AST_CLAMP_LONGER: assert property (@(posedge core_clk_in) disable iff (rst_in)
        BUS_TO_CYC > TX_TO_CYC) else $error("Clamping time not above transmit time-out.");

    AST_UV_DRIVER: assert property (@(posedge core_clk_in) disable iff (rst_in)
        uv_act |=> !drv_en_out ##0 bus_supply_uv_flag_out)
        else $error("Undervoltage did not stop the driver.");
endmodule : ctw_can_xcvr_ctrl

// ### ctw_pkg.sv
// Constants and shared types of the CAN transceiver mode, wake and fault block.
// Assumes one 10 MHz core clock; pin levels are synchronised inside the block.
package ctw_pkg;
    localparam int CTW_CNT_W = 24;
    localparam int CTW_CLK_PERIOD_NS = 100;
    localparam logic [CTW_CNT_W-1:0] CTW_CNT_ONE = 24'h000001;
    // Times in nanoseconds; least times round up, longest times round down.
    localparam int CTW_WAKE_MIN_NS = 500;
    localparam int CTW_WAKE_MAX_NS = 1800000;
    localparam int CTW_TX_TO_NS = 2700000;
    localparam int CTW_BUS_TO_NS = 3000000;
    localparam int CTW_SILENCE_NS = 900000;
    localparam logic [CTW_CNT_W-1:0] CTW_WAKE_MIN_CYC =
        24'((CTW_WAKE_MIN_NS + CTW_CLK_PERIOD_NS - 1) / CTW_CLK_PERIOD_NS);
    localparam logic [CTW_CNT_W-1:0] CTW_WAKE_MAX_CYC = 24'(CTW_WAKE_MAX_NS / CTW_CLK_PERIOD_NS);
    localparam logic [CTW_CNT_W-1:0] CTW_TX_TO_CYC =
        24'((CTW_TX_TO_NS + CTW_CLK_PERIOD_NS - 1) / CTW_CLK_PERIOD_NS);
    localparam logic [CTW_CNT_W-1:0] CTW_BUS_TO_CYC =
        24'((CTW_BUS_TO_NS + CTW_CLK_PERIOD_NS - 1) / CTW_CLK_PERIOD_NS);
    localparam logic [CTW_CNT_W-1:0] CTW_SILENCE_CYC =
        24'((CTW_SILENCE_NS + CTW_CLK_PERIOD_NS - 1) / CTW_CLK_PERIOD_NS);
    // Transceiver mode field codes.
    localparam logic [1:0] CTW_MODE_OFF = 2'h0;
    localparam logic [1:0] CTW_MODE_WAKE = 2'h1;
    localparam logic [1:0] CTW_MODE_RXO = 2'h2;
    localparam logic [1:0] CTW_MODE_NORM = 2'h3;
    // Chip operating mode codes.
    localparam logic [2:0] CTW_SBC_NORMAL = 3'h0;
    localparam logic [2:0] CTW_SBC_STOP = 3'h1;
    localparam logic [2:0] CTW_SBC_SLEEP = 3'h2;
    localparam logic [2:0] CTW_SBC_RESTART = 3'h3;
    localparam logic [2:0] CTW_SBC_FAILSAFE = 3'h4;
    // Termination selector codes.
    localparam logic [1:0] CTW_TERM_FLOAT = 2'h0;
    localparam logic [1:0] CTW_TERM_HALF = 2'h1;
    localparam logic [1:0] CTW_TERM_FIXED = 2'h2;
    localparam logic [1:0] CTW_TERM_GND = 2'h3;
    typedef enum logic [2:0] {PAT_IDLE, PAT_DOM1, PAT_REC, PAT_DOM2, PAT_STALE} ctw_pat_st_t;
    // Counters saturate so that a stuck level never wraps back into range.
    function automatic logic [CTW_CNT_W-1:0] ctw_sat_inc(input logic [CTW_CNT_W-1:0] v);
        ctw_sat_inc = (&v) ? v : v + CTW_CNT_ONE;
    endfunction : ctw_sat_inc
endpackage : ctw_pkg

// ### ctw_wake_if.sv
// Carrier between the transceiver control and its wake pattern detector.
// Assumes both ends share the core clock, which travels beside it.
`timescale 1ns/10ps
interface ctw_wake_if;
    logic bus_dom;
    logic enable;
    logic hit;
    modport det (input bus_dom, input enable, output hit);
    modport ctl (output bus_dom, output enable, input hit);
endinterface : ctw_wake_if

// ### ctw_wake_pattern.sv
// Wake pattern detector: dominant, recessive, dominant with bounded phase lengths.
// Assumes bus_dom is already synchronised to the core clock.
`timescale 1ns/10ps
module ctw_wake_pattern import ctw_pkg::*; #(
    parameter logic [CTW_CNT_W-1:0] MIN_CYC = CTW_WAKE_MIN_CYC,
    parameter logic [CTW_CNT_W-1:0] MAX_CYC = CTW_WAKE_MAX_CYC
) (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Link to the control logic.
    ctw_wake_if.det wif
);
    typedef struct packed {
        ctw_pat_st_t phase;
        logic [CTW_CNT_W-1:0] cnt;
        logic hit;
    } ctw_pat_state_t;

    ctw_pat_state_t st_ff;
    ctw_pat_state_t nxt_st;

    // Phase tracker; cnt holds the length of the current phase in cycles.
    // A phase that reaches MAX_CYC cycles with this one is already too long.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.hit = 1'b0;
        nxt_st.cnt = ctw_sat_inc(st_ff.cnt);
        if (!wif.enable) begin
            nxt_st.phase = PAT_IDLE;
            nxt_st.cnt = '0;
        end else begin
            case (st_ff.phase)
                PAT_IDLE: begin
                    nxt_st.cnt = CTW_CNT_ONE;
                    if (wif.bus_dom) nxt_st.phase = PAT_DOM1;
                end
                PAT_DOM1: begin
                    if (wif.bus_dom) begin
                        if (st_ff.cnt >= MAX_CYC - CTW_CNT_ONE) nxt_st.phase = PAT_STALE;
                    end else begin
                        nxt_st.cnt = CTW_CNT_ONE;
                        nxt_st.phase = (st_ff.cnt >= MIN_CYC) ? PAT_REC : PAT_IDLE;
                    end
                end
                PAT_REC: begin
                    if (!wif.bus_dom) begin
                        if (st_ff.cnt >= MAX_CYC - CTW_CNT_ONE) nxt_st.phase = PAT_IDLE;
                    end else begin
                        // A short gap restarts as a fresh first phase.
                        nxt_st.cnt = CTW_CNT_ONE;
                        nxt_st.phase = (st_ff.cnt > MIN_CYC) ? PAT_DOM2 : PAT_DOM1;
                    end
                end
                PAT_DOM2: begin
                    if (wif.bus_dom) begin
                        if (st_ff.cnt >= MAX_CYC - CTW_CNT_ONE) nxt_st.phase = PAT_STALE;
                    end else begin
                        nxt_st.hit = (st_ff.cnt >= MIN_CYC);
                        nxt_st.phase = PAT_IDLE;
                    end
                end
                PAT_STALE: begin
                    // Wait out an overlong dominant level before looking again.
                    if (!wif.bus_dom) nxt_st.phase = PAT_IDLE;
                end
                default: nxt_st.phase = PAT_IDLE;
            endcase
        end
    end

    // State register.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) st_ff <= '0;
        else st_ff <= nxt_st;
    end

    assign wif.hit = st_ff.hit;

    sequence s_dom2_closes;
        wif.enable && st_ff.phase == PAT_DOM2 && !wif.bus_dom && st_ff.cnt >= MIN_CYC;
    endsequence

    AST_PAT_HIT_FOLLOWS: assert property (@(posedge core_clk_in) disable iff (rst_in)
        s_dom2_closes |=> st_ff.hit) else $error("Valid second dominant phase missed.");

    AST_PAT_HIT_CAUSE: assert property (@(posedge core_clk_in) disable iff (rst_in)
        st_ff.hit |-> $past(st_ff.phase) == PAT_DOM2 && $past(st_ff.cnt) < MAX_CYC)
        else $error("Wake hit without a bounded second dominant phase.");
endmodule : ctw_wake_pattern

// ### tb.sv
// Self-checking bench for the transceiver control block.
// Assumes shortened timing parameters so that every time-out is reached quickly.
`timescale 1ns/10ps
module tb;
    import ctw_pkg::*;
    logic clk = 0, rst = 1, wr = 0, wclr = 0, fclr = 0, uclr = 0, tx = 1, uv = 0;
    logic [1:0] wd = 2'h0, mode, term;
    logic [2:0] sbc = 3'h0;
    logic wflag, fail, uvf, wauto, rreq, rx, irq_n, txdom, drv, brx;
    logic wd_opt = 1, wd_on = 0;
    // Pulse outputs are counted, and the notes carry the expected totals.
    logic [1:0] wcnt = 2'h0, rcnt = 2'h0, wexp = 2'h0, rexp = 2'h0;
    logic [13:0] expq[$];
    logic [13:0] got;
    logic [7:0] lfsr = 8'h44;
    int failures = 0, checks = 0, cyc = 0, a, b, c;
    event probe;
    // Core clock, 100 ns period.
    initial forever #50 clk = ~clk;
    ctw_can_xcvr_ctrl #(.WAKE_MAX_CYC(24'h000028), .TX_TO_CYC(24'h00001e),
        .BUS_TO_CYC(24'h000028), .SILENCE_CYC(24'h000014)) ctw_can_xcvr_ctrl_i (
        .core_clk_in(clk), .rst_in(rst), .mode_wr_in(wr), .mode_wdata_in(wd),
        .sbc_mode_in(sbc), .mode_out(mode), .wake_flag_clr_in(wclr),
        .can_fail_clr_in(fclr), .uv_flag_clr_in(uclr), .bus_wake_flag_out(wflag),
        .can_fail_flag_out(fail), .bus_supply_uv_flag_out(uvf),
        .wdog_on_bus_wake_in(wd_opt), .wdog_enabled_in(wd_on), .wdog_auto_en_out(wauto),
        .restart_req_out(rreq), .tx_data_pin_in(tx), .rx_data_pin_out(rx),
        .irq_out_n(irq_n), .bus_rx_in(brx), .transceiver_supply_uv_in(uv),
        .bus_tx_dom_out(txdom), .drv_en_out(drv), .term_sel_out(term));
    ctw_bus_model ctw_bus_model_i (.core_clk_in(clk), .bus_tx_dom_in(txdom), .bus_rx_out(brx));
    task tally_and_finish;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // Inputs always move 10 ns after the rising edge.
    task cyc_n(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : cyc_n
    task note(input logic [1:0] t, input logic [1:0] m, input logic [5:0] f);
        expq.push_back({wexp, rexp, t, m, f});
        ->probe;
    endtask : note
    task wr_mode(input logic [1:0] m);
        wr = 1;
        wd = m;
        cyc_n(1);
        wr = 0;
    endtask : wr_mode
    // Phase lengths of 6 to 25 cycles stay inside the legal wake window, which ends below 40 cycles.
    task rnd_len(output int n);
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        n = 6 + int'(lfsr % 8'h14);
    endtask : rnd_len
    // Watcher compares the observed outputs with the oldest note.
    always @(probe) begin
        got = expq.pop_front();
        checks++;
        if ({wcnt, rcnt, term, mode, drv, rx, irq_n, fail, uvf, wflag} !== got) begin
            failures++;
            $display("unexpected at %0t got %h exp %h", $time, {wcnt, rcnt, term, mode, drv,
                rx, irq_n, fail, uvf, wflag}, got);
        end
    end
    // Pulse counters sample at the falling edge, well away from the flops.
    always @(negedge clk) begin
        if (wauto) wcnt <= wcnt + 2'h1;
        if (rreq) rcnt <= rcnt + 2'h1;
    end
    // Hang guard.
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            failures++;
            tally_and_finish;
        end
    end
    initial begin
        cyc_n(4);
        rst = 0;
        cyc_n(2);
        note(2'h0, 2'h0, 6'h18);
        wr_mode(2'h3);
        cyc_n(3); // Transmit held recessive through enabling.
        note(2'h1, 2'h3, 6'h38);
        tx = 0;
        cyc_n(40);
        note(2'h1, 2'h3, 6'h1c);
        tx = 1;
        cyc_n(5);
        note(2'h1, 2'h3, 6'h3c);
        fclr = 1;
        uv = 1;
        cyc_n(1);
        fclr = 0;
        cyc_n(5);
        note(2'h1, 2'h3, 6'h1a);
        uv = 0;
        cyc_n(5);
        note(2'h1, 2'h3, 6'h3a);
        uclr = 1;
        sbc = 3'h1;
        cyc_n(1);
        uclr = 0;
        wr_mode(2'h2);
        cyc_n(2);
        note(2'h1, 2'h2, 6'h18);
        wr_mode(2'h3);
        cyc_n(2);
        note(2'h1, 2'h2, 6'h18);
        ctw_bus_model_i.send_wake(50, 1, 0);
        cyc_n(5);
        note(2'h1, 2'h2, 6'h1c);
        fclr = 1;
        cyc_n(1);
        fclr = 0;
        wr_mode(2'h1);
        cyc_n(25);
        rnd_len(a);
        rnd_len(b);
        rnd_len(c);
        ctw_bus_model_i.send_wake(a, b, c);
        cyc_n(6);
        wexp = 2'h1;
        note(2'h2, 2'h1, 6'h01);
        wr_mode(2'h0);
        cyc_n(2);
        note(2'h0, 2'h0, 6'h11);
        wclr = 1;
        cyc_n(1);
        wclr = 0;
        ctw_bus_model_i.send_wake(a, b, c);
        cyc_n(6);
        note(2'h0, 2'h0, 6'h18);
        sbc = 3'h2;
        wr_mode(2'h2);
        cyc_n(2);
        note(2'h0, 2'h0, 6'h18);
        wr_mode(2'h1);
        cyc_n(25);
        rnd_len(a);
        rnd_len(b);
        rnd_len(c);
        ctw_bus_model_i.send_wake(a, b, c);
        cyc_n(6);
        rexp = 2'h1;
        note(2'h2, 2'h1, 6'h09);
        sbc = 3'h4;
        wr_mode(2'h0);
        cyc_n(2);
        note(2'h3, 2'h1, 6'h19);
        ctw_bus_model_i.send_wake(a, b, c);
        cyc_n(6);
        rexp = 2'h2;
        note(2'h2, 2'h1, 6'h09);
        cyc_n(1);
        tally_and_finish;
    end
endmodule : tb
